// file: core/til_defs.vh
// constants of the terminal interrupt logger
`ifndef TIL_DEFS_VH
`define TIL_DEFS_VH
`define TIL_W 16
`define TIL_EV_N 16
// interrupt status word bit positions
`define TIL_B_ACCESSED 15
`define TIL_B_NORESP 14
`define TIL_B_RTMSGERR 13
`define TIL_B_DESCEVT 7
`define TIL_B_MODENODATA 6
`define TIL_B_ILLBCAST 5
`define TIL_B_ILLCMD 4
`define TIL_B_POLLMATCH 3
`define TIL_B_RETRYFAIL 2
`define TIL_B_MSGERR 1
`define TIL_B_INTCONT 0
`define TIL_RSVD_MASK 16'h1F00
// high-priority status bit positions
`define TIL_HP_STD 0
`define TIL_HP_DBC 1
`define TIL_HP_RST 16'h0000
`define TIL_PTR_RST 16'h0000
`endif

// file: core/til_sync2.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module til_sync2 #(
  parameter W = 1
) (
  input wire clk_sys, // system clock
  input wire srst, // synchronous reset
  input wire [W-1:0] pinIn, // asynchronous input
  output reg [W-1:0] syncOut // synchronised output
);
  reg [W-1:0] meta_r;
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end else begin
      meta_r <= pinIn;
      syncOut <= meta_r;
    end
  end
endmodule // til_sync2
`default_nettype wire

// file: core/til_word_build.v
// builds the interrupt status word from decoded events
`timescale 1ns/100ps
`include "til_defs.vh"
`default_nettype none
module til_word_build (
  input wire isBc, // bus controller role
  input wire noResp, // no-response time-out
  input wire rtMsgErr, // msg_error_flag in sent status
  input wire descEvt, // descriptor interrupt
  input wire modeNoData, // mode code without data interrupt
  input wire illBcast, // illegal broadcast receive
  input wire illCmd, // illegal command
  input wire pollMatch, // polling match
  input wire retryFail, // all retries failed
  input wire msgErr, // message error
  input wire intCont, // interrupt and continue
  output reg [`TIL_W-1:0] word // raw status word, accessed bit clear
);
  always @* begin
    word = 16'h0000;
    word[`TIL_B_NORESP] = noResp & msgErr;
    word[`TIL_B_RTMSGERR] = ~isBc & rtMsgErr;
    word[`TIL_B_DESCEVT] = ~isBc & descEvt;
    word[`TIL_B_MODENODATA] = ~isBc & modeNoData;
    word[`TIL_B_ILLBCAST] = ~isBc & illBcast;
    word[`TIL_B_ILLCMD] = ~isBc & illCmd;
    word[`TIL_B_POLLMATCH] = isBc & pollMatch;
    word[`TIL_B_RETRYFAIL] = isBc & retryFail;
    word[`TIL_B_MSGERR] = msgErr;
    word[`TIL_B_INTCONT] = isBc & intCont;
    word = word & ~`TIL_RSVD_MASK;
  end
endmodule // til_word_build
`default_nettype wire

// file: core/til_logger.v
// interrupt logger: irq outputs, status register, log-list DMA writer
// Function
// - each logged standard interrupt uses three words: status and pointer written, tail read
// - only enabled events create a log entry
// - bus controller entries carry the command block pointer in word two
// - third word is read and becomes the next entry address
// - after an entry the list pointer takes the tail pointer value
// - high-priority causes set status bits; writing one clears them
// - standard level rises on enabled event, held until its bit cleared
// - one standard pulse per enabled standard event
// - high-priority output per enabled event, cleared by writing its bit
// - status flags active high, bits 12 to 8 reserved zero
// - accessed bit 15 always set in the written status word
// - bit 14 marks message error caused by no-response time-out
// - remote terminal: bit 13 when sent status had message error
// - remote terminal: bit 7 on descriptor interrupt access
// - remote terminal: bit 6 on mode code without data interrupt
// - remote terminal: bit 5 on illegal broadcast receive command
// - remote terminal: bit 4 on illegal command
// - bus controller: bit 3 on polling comparison match
// - bus controller: bit 2 when all retries failed
// - both roles: bit 1 on any message error
// - bus controller: bit 0 on interrupt-and-continue block
// - dynamic bus control mode code raises enabled high-priority irq
// - forced busy suppresses all interrupts and all DMA
`timescale 1ns/100ps
`include "til_defs.vh"
`default_nettype none
module til_logger #(
  parameter AW = 16, // memory address width
  parameter DW = 16 // memory data width
) (
  input wire clk_sys, // system clock, 125 MHz
  input wire srst, // synchronous reset, active high
  input wire isBc, // operating as bus controller
  input wire forcedBusy, // forced busy state, level
  input wire dynBusCtlEn, // dynamic bus control enable
  input wire evtValid, // one-cycle strobe: message event
  input wire evNoResp, // event: no-response time-out
  input wire evRtMsgErr, // event: msg_error_flag in sent status
  input wire evDesc, // event: descriptor interrupt
  input wire evModeNoData, // event: mode code without data
  input wire evIllBcast, // event: illegal broadcast receive
  input wire evIllCmd, // event: illegal command
  input wire evPollMatch, // event: polling match
  input wire evRetryFail, // event: retries failed
  input wire evMsgErr, // event: message error
  input wire evIntCont, // event: interrupt and continue
  input wire evDynBusCtl, // event: dynamic bus control mode code
  input wire [AW-1:0] cmdBlkPtr, // command block pointer of message
  input wire [15:0] stdEnable, // standard interrupt enable register
  input wire [15:0] hpEnable, // high-priority enable register
  input wire [15:0] hpClrData, // write data to hp status/reset
  input wire hpClrWr, // write strobe to hp status/reset
  input wire [AW-1:0] listPtrData, // write data to list pointer
  input wire listPtrWr, // write strobe to list pointer
  output reg [15:0] hpStatus, // hp status/reset register
  output reg [AW-1:0] listPtr, // log list pointer register
  output reg std_irq_level, // standard interrupt level
  output reg std_irq_pulse, // standard interrupt pulse
  output wire high_prio_irq, // high-priority interrupt
  output reg dmaReq, // dma request, held until dmaAck, dropped while forced busy
  output reg dmaWe, // dma write when high, read when low
  output reg [AW-1:0] dmaAddr, // dma address
  output reg [DW-1:0] dmaWdata, // dma write data
  input wire dmaAck, // one-cycle dma completion
  input wire [DW-1:0] dmaRdata, // dma read data, valid with dmaAck
  output wire logBusy, // logging an entry
  output reg logOverrun // event dropped while busy, sticky
);
  localparam S_IDLE = 4'b0001;
  localparam S_WSTAT = 4'b0010;
  localparam S_WPTR = 4'b0100;
  localparam S_RTAIL = 4'b1000;

  wire [`TIL_W-1:0] rawWord;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [`TIL_W-1:0] entWord_r;
  reg [AW-1:0] entPtr_r;
  reg [AW-1:0] entBase_r;
  reg [15:0] hpSet;
  wire evHit;
  wire hpHit;
  wire [15:0] hpEvents;
  wire [15:0] hpNext;
  wire fbSync;

  // forced busy comes from a pin, two flops before use
  til_sync2 #(
    .W(1)
  ) u_fbsync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn(forcedBusy),
    .syncOut(fbSync)
  );

  til_word_build u_word (
    .isBc(isBc),
    .noResp(evNoResp),
    .rtMsgErr(evRtMsgErr),
    .descEvt(evDesc),
    .modeNoData(evModeNoData),
    .illBcast(evIllBcast),
    .illCmd(evIllCmd),
    .pollMatch(evPollMatch),
    .retryFail(evRetryFail),
    .msgErr(evMsgErr),
    .intCont(evIntCont),
    .word(rawWord)
  );

  // standard event only counts if an enabled bit is present
  assign evHit = evtValid & ~fbSync & |(rawWord & stdEnable);
  assign hpEvents = rawWord |
    ({15'h0000, evDynBusCtl & dynBusCtlEn & evtValid} << `TIL_HP_DBC);
  assign hpHit = evtValid & ~fbSync & |(hpEvents & hpEnable);
  assign hpNext = (hpStatus & ~(hpClrWr ? hpClrData : 16'h0000)) | hpSet;
  assign high_prio_irq = |(hpStatus & ~(16'h0001 << `TIL_HP_STD));
  assign logBusy = ~state_r[0];

  always @* begin
    hpSet = 16'h0000;
    if (evHit) begin
      hpSet[`TIL_HP_STD] = 1'b1;
    end
    if (hpHit) begin
      hpSet = hpSet | (hpEvents & hpEnable &
        ~(16'h0001 << `TIL_HP_STD));
    end
  end

  // high-priority status: set wins over a one written at the same time
  always @(posedge clk_sys) begin
    if (srst) begin
      hpStatus <= `TIL_HP_RST;
      std_irq_level <= 1'b0;
      std_irq_pulse <= 1'b0;
    end else begin
      hpStatus <= hpNext;
      std_irq_level <= hpNext[`TIL_HP_STD];
      std_irq_pulse <= evHit;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (evHit) begin
          state_nxt = S_WSTAT;
        end
      end
      S_WSTAT: begin
        if (dmaAck) begin
          state_nxt = S_WPTR;
        end
      end
      S_WPTR: begin
        if (dmaAck) begin
          state_nxt = S_RTAIL;
        end
      end
      S_RTAIL: begin
        if (dmaAck) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_r <= S_IDLE;
      entWord_r <= 16'h0000;
      entPtr_r <= {AW{1'b0}};
      entBase_r <= {AW{1'b0}};
      listPtr <= `TIL_PTR_RST;
      logOverrun <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r[0] && evHit) begin
        entWord_r <= rawWord | (16'h0001 << `TIL_B_ACCESSED);
        entPtr_r <= isBc ? cmdBlkPtr : {AW{1'b0}};
        entBase_r <= listPtr;
      end
      if (!state_r[0] && evHit) begin
        logOverrun <= 1'b1;
      end
      if (state_r == S_RTAIL && dmaAck) begin
        listPtr <= dmaRdata[AW-1:0];
      end else if (listPtrWr && state_r[0]) begin
        listPtr <= listPtrData;
      end
    end
  end

  // dma: status word, pointer word, then tail read, consecutive addresses
  always @* begin
    dmaReq = 1'b0;
    dmaWe = 1'b0;
    dmaAddr = entBase_r;
    dmaWdata = {DW{1'b0}};
    case (state_r)
      S_WSTAT: begin
        dmaReq = ~fbSync;
        dmaWe = 1'b1;
        dmaWdata = entWord_r[DW-1:0];
      end
      S_WPTR: begin
        dmaReq = ~fbSync;
        dmaWe = 1'b1;
        dmaAddr = entBase_r + {{(AW-1){1'b0}}, 1'b1};
        dmaWdata = entPtr_r[DW-1:0];
      end
      S_RTAIL: begin
        dmaReq = ~fbSync;
        dmaAddr = entBase_r + {{(AW-2){1'b0}}, 2'b10};
      end
      default: begin
        dmaReq = 1'b0;
      end
    endcase
  end
endmodule // til_logger
`default_nettype wire

// file: bench/til_logger_sva.sv
// assertions on the interrupt logger ports
`timescale 1ns/100ps
`default_nettype none
module til_logger_sva #(
  parameter AW = 16, // address width
  parameter DW = 16 // data width
) (
  input wire logic clk_sys, // clock
  input wire logic srst, // reset
  input wire logic evtValid, // event
  input wire logic forcedBusy, // busy
  input wire logic hpClrWr, // clear strobe
  input wire logic [15:0] hpClrData, // clear bits
  input wire logic std_irq_pulse, // pulse
  input wire logic std_irq_level, // level
  input wire logic high_prio_irq, // hp irq
  input wire logic dmaReq, // request
  input wire logic dmaWe, // write
  input wire logic dmaAck, // done
  input wire logic [AW-1:0] dmaAddr, // address
  input wire logic [DW-1:0] dmaWdata, // data
  input wire logic [DW-1:0] dmaRdata, // read data
  input wire logic [AW-1:0] listPtr // list pointer
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence sStart; $rose(dmaReq); endsequence
  sequence sFirstDone; dmaReq && dmaWe && dmaAck && dmaAddr == listPtr;
  endsequence
  sequence sTailRead; dmaReq && !dmaWe && dmaAck; endsequence
  pulse_one_clk_a: assert property (std_irq_pulse |=> !std_irq_pulse)
    else $error("pulse too long");
  pulse_cause_a: assert property (std_irq_pulse |-> $past(evtValid))
    else $error("pulse without event");
  level_hold_a: assert property (std_irq_level &&
    !(hpClrWr && hpClrData[0]) |=> std_irq_level) else $error("level lost");
  hp_cause_a: assert property ($rose(high_prio_irq) |-> $past(evtValid))
    else $error("hp irq without event");
  hp_clear_a: assert property (hpClrWr && hpClrData == 16'hFFFF &&
    !evtValid |=> !high_prio_irq) else $error("hp irq not cleared");
  busy_no_dma_a: assert property (forcedBusy && $past(forcedBusy) &&
    $past(forcedBusy, 2) |-> !dmaReq && !std_irq_pulse)
    else $error("dma in forced busy");
  first_word_a: assert property (sStart |-> dmaWe &&
    dmaAddr == listPtr && dmaWdata[15] && dmaWdata[12:8] == 5'h00)
    else $error("bad status word");
  req_hold_a: assert property (dmaReq && !dmaAck |=> dmaReq &&
    $stable(dmaAddr) && $stable(dmaWe)) else $error("request dropped");
  word_order_a: assert property (sFirstDone |=> dmaReq && dmaWe &&
    dmaAddr == listPtr + 16'h0001) else $error("second word misplaced");
  tail_load_a: assert property (sTailRead |=> listPtr == $past(dmaRdata))
    else $error("tail not loaded");
endmodule // til_logger_sva
bind til_logger til_logger_sva #(.AW(AW), .DW(DW)) i_sva (.clk_sys, .srst,
  .evtValid, .forcedBusy, .hpClrWr, .hpClrData, .std_irq_pulse,
  .std_irq_level, .high_prio_irq, .dmaReq, .dmaWe, .dmaAck, .dmaAddr,
  .dmaWdata, .dmaRdata, .listPtr);
`default_nettype wire

// file: bench/til_mem_model.sv
// system memory answering the logger dma
`timescale 1ns/100ps
`default_nettype none
module til_mem_model (
  input wire logic clk_sys, // clock
  input wire logic dmaReq, // request
  input wire logic dmaWe, // write
  input wire logic [15:0] dmaAddr, // address
  input wire logic [15:0] dmaWdata, // data
  input wire logic slow, // stretch answer
  output logic dmaAck, // done
  output logic [15:0] dmaRdata // read data
);
  logic [15:0] mem [0:255];
  int waitN = 0;
  initial begin
    dmaAck = 1'b0;
    dmaRdata = 16'h0000;
  end
  always @(posedge clk_sys) begin
    dmaAck <= 1'b0;
    dmaRdata <= ~dmaRdata;
    if (dmaReq && !dmaAck) begin
      if (waitN < (slow ? 3 : 0)) waitN <= waitN + 1;
      else begin
        waitN <= 0;
        dmaAck <= 1'b1;
        if (dmaWe) mem[dmaAddr[7:0]] <= dmaWdata;
        else dmaRdata <= mem[dmaAddr[7:0]];
      end
    end
  end
endmodule // til_mem_model
`default_nettype wire

// file: bench/tb.sv
// testbench of the interrupt logger
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys = 0, srst = 1, isBc = 0, forcedBusy = 0, dynBusCtlEn = 0;
  logic evtValid = 0, hpClrWr = 0, listPtrWr = 0, slow = 0, bc;
  logic [15:0] ev = 0, stdEnable = 0, hpEnable = 0, hpClrData = 0, e, lp;
  logic [15:0] cmdBlkPtr = 0, listPtrData = 0, hpStatus, listPtr;
  logic [15:0] dmaAddr, dmaWdata, dmaRdata;
  logic std_irq_level, std_irq_pulse, high_prio_irq, dmaReq, dmaWe;
  logic dmaAck, logBusy, logOverrun;
  logic [31:0] expQ [$];
  int n_mismatch = 0, n_tests = 0, nPulse = 0, nExp = 0;
  int bits [10] = '{14, 13, 7, 6, 5, 4, 3, 2, 1, 0};
  til_logger i_til_logger (.clk_sys, .srst, .isBc, .forcedBusy,
    .dynBusCtlEn, .evtValid, .evNoResp(ev[14]), .evRtMsgErr(ev[13]),
    .evDesc(ev[7]), .evModeNoData(ev[6]), .evIllBcast(ev[5]),
    .evIllCmd(ev[4]), .evPollMatch(ev[3]), .evRetryFail(ev[2]),
    .evMsgErr(ev[1]), .evIntCont(ev[0]), .evDynBusCtl(ev[9]), .cmdBlkPtr,
    .stdEnable, .hpEnable, .hpClrData, .hpClrWr, .listPtrData, .listPtrWr,
    .hpStatus, .listPtr, .std_irq_level, .std_irq_pulse, .high_prio_irq,
    .dmaReq, .dmaWe, .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata, .logBusy,
    .logOverrun);
  til_mem_model i_til_mem_model (.clk_sys, .dmaReq, .dmaWe, .dmaAddr,
    .dmaWdata, .slow, .dmaAck, .dmaRdata);
  initial forever #4 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [15:0] x, logic [15:0] s);
    n_tests++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // monitor: each dma write takes the oldest expected word
  always @(posedge clk_sys) begin
    logic [31:0] w;
    if (std_irq_pulse) nPulse++;
    if (dmaReq && dmaAck && dmaWe) begin
      w = expQ.size() ? expQ.pop_front() : 32'hXXXXXXXX;
      chk("dma addr", w[31:16], dmaAddr);
      chk("dma word", w[15:0], dmaWdata);
    end
  end
  task automatic logEvt(logic [15:0] v, logic r, logic en, logic fb);
    @(negedge clk_sys);
    forcedBusy = fb;
    repeat (2) @(negedge clk_sys);
    ev = v;
    isBc = r;
    slow = 1'($urandom);
    cmdBlkPtr = 16'($urandom);
    stdEnable = en ? 16'($urandom) | v : 16'($urandom) & ~v;
    evtValid = 1;
    if (en && !fb) begin
      nExp++;
      expQ.push_back({lp, 16'h8000 | v});
      expQ.push_back({lp + 16'h0001, r ? cmdBlkPtr : 16'h0000});
      lp = lp + 16'h0008;
    end
    @(negedge clk_sys);
    evtValid = 0;
    ev = 0;
    forcedBusy = 0;
    for (int i = 0; i < 40 && (logBusy || dmaReq); i++) @(negedge clk_sys);
    chk("list ptr", lp, listPtr);
  endtask
  task automatic clr(logic [15:0] d);
    @(negedge clk_sys);
    hpClrData = d;
    hpClrWr = 1;
    @(negedge clk_sys);
    hpClrWr = 0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    void'($urandom(82949));
    repeat (10) @(negedge clk_sys);
    srst = 0;
    chk("hp status", 16'h0000, hpStatus);
    chk("list ptr", 16'h0000, listPtr);
    $display("end reset test");
    for (int k = 0; k < 20; k++)
      i_til_mem_model.mem[18 + 8 * k] = 16'(24 + 8 * k);
    listPtrData = 16'h0010;
    listPtrWr = 1;
    lp = 16'h0010;
    @(negedge clk_sys);
    listPtrWr = 0;
    foreach (bits[i]) begin
      e = bits[i] == 14 ? 16'h4002 : 16'h0001 << bits[i];
      bc = bits[i] inside {0, 2, 3} ? 1'b1 : 1'($urandom);
      if (bits[i] inside {13, 7, 6, 5, 4}) bc = 1'b0;
      logEvt(e, bc, 1'b1, 1'b0);
    end
    $display("end entry test");
    logEvt(16'h0002, 1'b0, 1'b0, 1'b0);
    logEvt(16'h0010, 1'b0, 1'b1, 1'b1);
    chk("pulse count", 16'(nExp), 16'(nPulse));
    chk("std level", 16'h0001, {15'h0000, std_irq_level});
    clr(16'h0001);
    chk("std level", 16'h0000, {15'h0000, std_irq_level});
    $display("end level test");
    hpEnable = 16'h0002;
    dynBusCtlEn = 1;
    logEvt(16'h0200, 1'b0, 1'b0, 1'b0);
    chk("hp irq", 16'h0001, {15'h0000, high_prio_irq});
    chk("hp status", 16'h0002, hpStatus);
    clr(16'hFFFF);
    chk("hp irq", 16'h0000, {15'h0000, high_prio_irq});
    logEvt(16'h0002, 1'b1, 1'b1, 1'b0);
    chk("hp irq", 16'h0001, {15'h0000, high_prio_irq});
    clr(16'hFFFF);
    chk("hp irq", 16'h0000, {15'h0000, high_prio_irq});
    chk("left words", 16'h0000, 16'(expQ.size()));
    chk("overrun", 16'h0000, {15'h0000, logOverrun});
    $display("end high priority test");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
